// ### rtl/ldt_pkg.sv
// constants, register map and types for the long count timer
// How it works
// [R1] the count is a 24-bit counter advanced from a dedicated 32768 Hz oscillator tick.
// [R2] in normal operation the tick is divided by 16 then 2048, so one count is one second.
// [R3] in calibration mode the second prescaler is skipped and the tick is divided by 16 only.
// [R4] the timer is configured over the register bus and counts in normal and low power off mode.
// [R5] the timer can be started in normal mode with either prescaler option selected.
// [R6] the host calibrates by running the counter for a known time and reading back the count.
// [R7] a 16-bit after-run target and a 24-bit wake-up target are writable and readable.
// [R8] after reset the timer idles; after-run counting starts on run enable, wake-up on low power off in functions 4 and 5 and on the after-run hit in function 3.
// [R9] in function 1, reaching the after-run target raises an interrupt and stops the counter.
// [R10] the host clears run enable before reading the count and sets it again to resume.
// [R11] the prescaler path only changes between normal and calibration while run enable is clear.
package ldt_pkg;
  localparam int unsigned LDT_CLK_HZ = 10_000_000;
  localparam int unsigned LDT_OSC_HZ = 32768;
  localparam int unsigned LDT_PRE1_DIV = 16;
  localparam int unsigned LDT_PRE2_DIV = 2048;
  localparam int unsigned LDT_CNT_W = 24;
  localparam int unsigned LDT_AR_W = 16;

  // register byte offsets
  localparam logic [4:0] LDT_OFF_CTRL = 5'h00;
  localparam logic [4:0] LDT_OFF_AFTER = 5'h04;
  localparam logic [4:0] LDT_OFF_WAKE = 5'h08;
  localparam logic [4:0] LDT_OFF_COUNT = 5'h0C;
  localparam logic [4:0] LDT_OFF_STAT = 5'h10;
  localparam logic [4:0] LDT_OFF_MASK = 5'h14;
  localparam logic [4:0] LDT_OFF_STATE = 5'h18;

  // timer functions
  localparam logic [2:0] LDT_FN_IRQ = 3'h1;
  localparam logic [2:0] LDT_FN_OFF = 3'h2;
  localparam logic [2:0] LDT_FN_OFF_WAKE = 3'h3;
  localparam logic [2:0] LDT_FN_WAKE = 3'h4;
  localparam logic [2:0] LDT_FN_OVF = 3'h5;

  // status bit positions
  localparam int unsigned LDT_ST_AFTER = 0;
  localparam int unsigned LDT_ST_WAKE = 1;
  localparam int unsigned LDT_ST_OVF = 2;
  localparam int unsigned LDT_ST_OTHER = 3;
  localparam int unsigned LDT_ST_W = 4;

  localparam logic [31:0] LDT_RST_WORD = 32'h0000_0000;

  typedef struct packed {
    logic clear_count;
    logic cal_mode;
    logic [2:0] func;
    logic timer_run_enable;
  } ldt_ctrl_t;

  typedef enum logic [4:0] {
    LDT_IDLE = 5'b00001,
    LDT_AFTER_RUN = 5'b00010,
    LDT_LP_WAIT = 5'b00100,
    LDT_WAKE_RUN = 5'b01000,
    LDT_STOPPED = 5'b10000
  } ldt_state_t;
endpackage

// ### rtl/ldt_prescaler.sv
// oscillator tick generator and two-stage prescaler
module ldt_prescaler
  import ldt_pkg::*;
#(
  parameter int unsigned CLK_HZ = LDT_CLK_HZ,
  parameter int unsigned OSC_HZ = LDT_OSC_HZ,
  parameter int unsigned PRE1_DIV = LDT_PRE1_DIV,
  parameter int unsigned PRE2_DIV = LDT_PRE2_DIV
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // control
  input wire logic run_i,
  input wire logic cal_i,
  // count enable
  output logic tick_o
);
  localparam int unsigned ACC_W = $clog2(CLK_HZ) + 1;
  localparam logic [ACC_W-1:0] OSC_STEP = ACC_W'(OSC_HZ);
  localparam logic [ACC_W-1:0] CLK_MOD = ACC_W'(CLK_HZ);
  localparam logic [3:0] PRE1_LAST = 4'(PRE1_DIV - 1);
  localparam logic [10:0] PRE2_LAST = 11'(PRE2_DIV - 1);

  logic [ACC_W-1:0] acc_q;
  logic osc_tick;
  logic [3:0] pre1_q;
  logic [10:0] pre2_q;
  logic pre1_tick;

  // fractional accumulator stands in for the free-running oscillator
  assign osc_tick = (acc_q + OSC_STEP) >= CLK_MOD; // [R1]

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      acc_q <= '0;
    end else if (osc_tick) begin
      acc_q <= acc_q + OSC_STEP - CLK_MOD;
    end else begin
      acc_q <= acc_q + OSC_STEP;
    end
  end

  assign pre1_tick = run_i && osc_tick && (pre1_q == PRE1_LAST);

  // prescalers hold while stopped so a paused count resumes without a lost fraction
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pre1_q <= '0;
    end else if (run_i && osc_tick) begin
      pre1_q <= (pre1_q == PRE1_LAST) ? 4'h0 : pre1_q + 4'h1; // [R2]
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pre2_q <= '0;
    end else if (pre1_tick && !cal_i) begin
      pre2_q <= (pre2_q == PRE2_LAST) ? 11'h000 : pre2_q + 11'h001; // [R2]
    end
  end

  assign tick_o = pre1_tick && (cal_i || pre2_q == PRE2_LAST); // [R2] [R3]
endmodule // ldt_prescaler

// ### rtl/ldt_timer.sv
// long count timer with avalon-mm register slave
module ldt_timer
  import ldt_pkg::*;
#(
  parameter int unsigned CNT_W = LDT_CNT_W,
  parameter int unsigned AR_W = LDT_AR_W
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // avalon-mm slave
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // power mode interface
  input wire logic low_power_off_mode_i,
  input wire logic other_wake_i,
  output logic low_power_off_mode_request_o,
  output logic wake_request_o,
  // interrupt
  output logic irq_o
);
  ldt_ctrl_t ctrl_q;
  logic cal_sel_q;
  logic [AR_W-1:0] after_q;
  logic [CNT_W-1:0] wake_q;
  logic [CNT_W-1:0] count_q;
  logic [LDT_ST_W-1:0] stat_q;
  logic [LDT_ST_W-1:0] mask_q;
  logic [31:0] rdata_q;
  logic ack_q;
  logic low_power_off_mode_q;
  logic wake_q_pulse;
  ldt_state_t state_q;
  logic req;
  logic wr_en;
  logic rd_en;
  logic counting;
  logic tick;
  logic hit_after;
  logic hit_wake;
  logic hit_ovf;
  logic lp_rise;
  logic [LDT_ST_W-1:0] ev;

  // answer on the second cycle of every access
  assign req = avs_read_i || avs_write_i;
  assign avs_waitrequest_o = req && !ack_q;
  assign wr_en = avs_write_i && ack_q;
  assign rd_en = avs_read_i && ack_q;
  assign avs_readdata_o = rdata_q;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req && !ack_q;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rdata_q <= LDT_RST_WORD;
    end else if (avs_read_i && !ack_q) begin
      case (avs_address_i)
        LDT_OFF_CTRL: rdata_q <= 32'(ctrl_q);
        LDT_OFF_AFTER: rdata_q <= 32'(after_q); // [R7]
        LDT_OFF_WAKE: rdata_q <= 32'(wake_q); // [R7]
        LDT_OFF_COUNT: rdata_q <= 32'(count_q); // [R6] [R10]
        LDT_OFF_STAT: rdata_q <= 32'(stat_q);
        LDT_OFF_MASK: rdata_q <= 32'(mask_q);
        LDT_OFF_STATE: rdata_q <= {26'h0, cal_sel_q, state_q};
        default: rdata_q <= LDT_RST_WORD;
      endcase
    end
  end

  // configuration registers
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      ctrl_q <= '0;
    end else if (wr_en && avs_address_i == LDT_OFF_CTRL) begin
      ctrl_q <= ldt_ctrl_t'(avs_writedata_i[5:0]); // [R4] [R5]
    end else begin
      ctrl_q.clear_count <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      after_q <= '0;
      wake_q <= '0;
      mask_q <= '0;
    end else if (wr_en) begin
      if (avs_address_i == LDT_OFF_AFTER) after_q <= avs_writedata_i[AR_W-1:0]; // [R7]
      if (avs_address_i == LDT_OFF_WAKE) wake_q <= avs_writedata_i[CNT_W-1:0]; // [R7]
      if (avs_address_i == LDT_OFF_MASK) mask_q <= avs_writedata_i[LDT_ST_W-1:0];
    end
  end

  // a mid-run switch would leave a partial second-stage count, so only take it while stopped
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      cal_sel_q <= 1'b0;
    end else if (!ctrl_q.timer_run_enable) begin
      cal_sel_q <= ctrl_q.cal_mode; // [R11]
    end
  end

  assign counting = ctrl_q.timer_run_enable &&
                    (state_q == LDT_AFTER_RUN || state_q == LDT_WAKE_RUN); // [R4] [R10]

  ldt_prescaler u_pre (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .run_i(counting),
    .cal_i(cal_sel_q),
    .tick_o(tick)
  );

  assign hit_after = state_q == LDT_AFTER_RUN && count_q == CNT_W'(after_q);
  assign hit_wake = state_q == LDT_WAKE_RUN && ctrl_q.func != LDT_FN_OVF && count_q == wake_q;
  assign hit_ovf = state_q == LDT_WAKE_RUN && ctrl_q.func == LDT_FN_OVF && (&count_q);

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      low_power_off_mode_q <= 1'b0;
    end else begin
      low_power_off_mode_q <= low_power_off_mode_i;
    end
  end
  assign lp_rise = low_power_off_mode_i && !low_power_off_mode_q;

  // timer state machine
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || ctrl_q.clear_count) begin
      state_q <= LDT_IDLE; // [R8]
    end else begin
      case (state_q)
        LDT_IDLE: begin
          if (ctrl_q.timer_run_enable) begin
            if (ctrl_q.func == LDT_FN_WAKE || ctrl_q.func == LDT_FN_OVF) begin
              state_q <= LDT_LP_WAIT;
            end else begin
              state_q <= LDT_AFTER_RUN; // [R8] [R5]
            end
          end
        end
        LDT_AFTER_RUN: begin
          if (hit_after) begin
            state_q <= (ctrl_q.func == LDT_FN_OFF_WAKE) ? LDT_WAKE_RUN : LDT_STOPPED; // [R9]
          end
        end
        LDT_LP_WAIT: begin
          if (lp_rise) state_q <= LDT_WAKE_RUN; // [R8]
        end
        LDT_WAKE_RUN: begin
          if (hit_wake || hit_ovf) state_q <= LDT_STOPPED;
        end
        LDT_STOPPED: state_q <= LDT_STOPPED;
        default: state_q <= LDT_IDLE;
      endcase
    end
  end

  // counter is cleared on restart and on the after-run to wake-up handover
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || ctrl_q.clear_count) begin
      count_q <= '0;
    end else if (state_q == LDT_AFTER_RUN && hit_after && ctrl_q.func == LDT_FN_OFF_WAKE) begin
      count_q <= '0;
    end else if (counting && tick && !hit_after && !hit_wake && !hit_ovf) begin
      count_q <= count_q + CNT_W'(1); // [R1]
    end
  end

  // power mode requests, one cycle each
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      low_power_off_mode_request_o <= 1'b0;
      wake_q_pulse <= 1'b0;
    end else begin
      low_power_off_mode_request_o <= hit_after &&
                         (ctrl_q.func == LDT_FN_OFF || ctrl_q.func == LDT_FN_OFF_WAKE);
      wake_q_pulse <= hit_wake || hit_ovf;
    end
  end
  assign wake_request_o = wake_q_pulse;

  // sticky events; a new event wins over the clear-on-read
  assign ev[LDT_ST_AFTER] = hit_after; // [R9]
  assign ev[LDT_ST_WAKE] = hit_wake;
  assign ev[LDT_ST_OVF] = hit_ovf;
  assign ev[LDT_ST_OTHER] = other_wake_i && state_q == LDT_WAKE_RUN;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      stat_q <= '0;
    end else if (rd_en && avs_address_i == LDT_OFF_STAT) begin
      stat_q <= ev;
    end else begin
      stat_q <= stat_q | ev;
    end
  end

  assign irq_o = |(stat_q & mask_q); // [R9]
endmodule // ldt_timer

// ### testbench/ldt_timer_chk.sv
// port checker for the long count timer
module ldt_timer_chk (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // register bus
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // power mode and interrupt
  input wire logic low_power_off_mode_i,
  input wire logic low_power_off_mode_request_o,
  input wire logic wake_request_o,
  input wire logic irq_o
);
  logic req;
  assign req = avs_read_i | avs_write_i;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_wait_first; $rose(req) |-> avs_waitrequest_o; endproperty
  a_wait_first: assert property (p_wait_first) else $error("no wait cycle");
  property p_one_wait; $rose(req) ##1 req |-> !avs_waitrequest_o; endproperty
  a_one_wait: assert property (p_one_wait) else $error("wait too long");
  property p_idle_wait; !req |-> !avs_waitrequest_o; endproperty
  a_idle_wait: assert property (p_idle_wait) else $error("wait while idle");
  property p_rdata_hold; $changed(avs_readdata_o) |-> $past(avs_read_i); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_lp_pulse; low_power_off_mode_request_o |=> !low_power_off_mode_request_o; endproperty
  a_lp_pulse: assert property (p_lp_pulse) else $error("long entry pulse");
  property p_lp_normal; low_power_off_mode_request_o |-> !low_power_off_mode_i; endproperty
  a_lp_normal: assert property (p_lp_normal) else $error("entry while off");
  property p_wk_pulse; wake_request_o |=> !wake_request_o; endproperty
  a_wk_pulse: assert property (p_wk_pulse) else $error("long wake pulse");
  property p_wk_off; wake_request_o |-> low_power_off_mode_i; endproperty
  a_wk_off: assert property (p_wk_off) else $error("wake outside off");
  property p_irq_fall; $fell(irq_o) |-> $past(req && !avs_waitrequest_o); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
  c_irq: cover property ($rose(irq_o));
  c_lp: cover property (low_power_off_mode_request_o);
  c_wk: cover property (wake_request_o ##[1:3] !low_power_off_mode_i);
endmodule // ldt_timer_chk

bind ldt_timer ldt_timer_chk i_ldt_timer_chk (.*);

// ### testbench/ldt_power_model.sv
// power mode partner: enters low power off on request, leaves on wake
module ldt_power_model (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // requests from the timer
  input wire logic low_power_off_mode_request_i,
  input wire logic wake_request_i,
  // host command to enter low power off directly
  input wire logic enter_i,
  // mode level back to the timer
  output logic low_power_off_mode_o
);
  logic lp_q;
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      lp_q <= 1'b0;
    end else if (low_power_off_mode_request_i || enter_i) begin
      lp_q <= 1'b1;
    end else if (wake_request_i) begin
      lp_q <= 1'b0;
    end
  end
  assign low_power_off_mode_o = lp_q;
endmodule // ldt_power_model

// ### testbench/ldt_timer_tb.sv
// self-checking bench for the long count timer
module ldt_timer_tb import ldt_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [4:0] avs_address_i = 5'h0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic low_power_off_mode_i;
  logic other_wake_i = 1'b0;
  logic enter_lp = 1'b0;
  logic low_power_off_mode_request_o;
  logic wake_request_o;
  logic irq_o;
  int miscompares = 0;
  int check_count = 0;
  always #50 core_clk_i = ~core_clk_i;
  ldt_timer i_ldt_timer (.*);
  ldt_power_model i_ldt_power_model (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .low_power_off_mode_request_i(low_power_off_mode_request_o), .wake_request_i(wake_request_o), .enter_i(enter_lp),
    .low_power_off_mode_o(low_power_off_mode_i));
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge core_clk_i);
    if (n >= 50) begin
      miscompares++;
      end_of_test();
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  // 0 irq, 1 entry request, 2 wake request
  task automatic wait_ev(input int s);
    int n;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (n < 30000 && (s == 0 ? irq_o : s == 1 ? low_power_off_mode_request_o : wake_request_o) !== 1'b1);
    if (n >= 30000) begin
      miscompares++;
      end_of_test();
    end
  endtask
  task automatic t_reset();
    rd(LDT_OFF_CTRL, 32'h0);
    rd(LDT_OFF_COUNT, 32'h0);
    rd(LDT_OFF_STAT, 32'h0);
    rd(LDT_OFF_STATE, 32'h1);
    chk({31'h0, irq_o}, 32'h0);
  endtask
  task automatic t_regs();
    wr(LDT_OFF_AFTER, 32'hFFFF_FFFF);
    rd(LDT_OFF_AFTER, 32'hFFFF);
    wr(LDT_OFF_WAKE, 32'hFFFF_FFFF);
    rd(LDT_OFF_WAKE, 32'hFF_FFFF);
    wr(LDT_OFF_COUNT, 32'h5);
    rd(LDT_OFF_COUNT, 32'h0);
    wr(5'h1c, 32'h1);
    rd(5'h1c, 32'h0);
  endtask
  task automatic t_normal();
    wr(LDT_OFF_CTRL, 32'h3);
    // longer than one calibration count, far short of one second
    repeat (6000) @(posedge core_clk_i);
    wr(LDT_OFF_CTRL, 32'h2);
    rd(LDT_OFF_COUNT, 32'h0);
    rd(LDT_OFF_STATE, 32'h2);
  endtask
  task automatic t_cal_irq();
    wr(LDT_OFF_CTRL, 32'h12);
    wr(LDT_OFF_AFTER, 32'h2);
    wr(LDT_OFF_MASK, 32'h1);
    wr(LDT_OFF_CTRL, 32'h13);
    wait_ev(0);
    wr(LDT_OFF_CTRL, 32'h12);
    rd(LDT_OFF_COUNT, 32'h2);
    rd(LDT_OFF_STATE, 32'h30);
    wr(LDT_OFF_MASK, 32'h0);
    chk({31'h0, irq_o}, 32'h0);
    wr(LDT_OFF_MASK, 32'h1);
    chk({31'h0, irq_o}, 32'h1);
    rd(LDT_OFF_STAT, 32'h1);
    chk({31'h0, irq_o}, 32'h0);
    rd(LDT_OFF_STAT, 32'h0);
  endtask
  task automatic t_func3();
    wr(LDT_OFF_CTRL, 32'h36);
    rd(LDT_OFF_STATE, 32'h21);
    wr(LDT_OFF_AFTER, 32'h1);
    wr(LDT_OFF_WAKE, 32'h1);
    wr(LDT_OFF_MASK, 32'h0);
    wr(LDT_OFF_CTRL, 32'h17);
    wait_ev(1);
    wait_ev(2);
    chk({31'h0, irq_o}, 32'h0);
    wr(LDT_OFF_CTRL, 32'h16);
    rd(LDT_OFF_COUNT, 32'h1);
    rd(LDT_OFF_STAT, 32'h3);
  endtask
  // wake-up counting arms on the host-driven entry into low power off
  task automatic t_func4();
    wr(LDT_OFF_CTRL, 32'h38);
    wr(LDT_OFF_WAKE, 32'h1);
    wr(LDT_OFF_CTRL, 32'h19);
    rd(LDT_OFF_STATE, 32'h24);
    enter_lp <= 1'b1;
    @(posedge core_clk_i);
    enter_lp <= 1'b0;
    wait_ev(2);
    wr(LDT_OFF_CTRL, 32'h18);
    rd(LDT_OFF_COUNT, 32'h1);
    rd(LDT_OFF_STAT, 32'h2);
    rd(LDT_OFF_STATE, 32'h30);
  endtask
  // overflow function keeps counting and records another wake source
  task automatic t_func5();
    wr(LDT_OFF_CTRL, 32'h3A);
    wr(LDT_OFF_CTRL, 32'h1B);
    rd(LDT_OFF_STATE, 32'h24);
    enter_lp <= 1'b1;
    @(posedge core_clk_i);
    enter_lp <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    rd(LDT_OFF_STATE, 32'h28);
    other_wake_i <= 1'b1;
    @(posedge core_clk_i);
    other_wake_i <= 1'b0;
    @(posedge core_clk_i);
    wr(LDT_OFF_MASK, 32'h8);
    chk({31'h0, irq_o}, 32'h1);
    rd(LDT_OFF_STAT, 32'h8);
    chk({31'h0, irq_o}, 32'h0);
    rd(LDT_OFF_STATE, 32'h28);
  endtask
  initial begin
    repeat (5) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge core_clk_i);
    t_reset();
    t_regs();
    t_normal();
    t_cal_irq();
    t_func3();
    t_func4();
    t_func5();
    end_of_test();
  end
endmodule // ldt_timer_tb
